// [include/addr_select_pkg.sv]
// package: pad states, address constants and carried struct
package addr_select_pkg;

    // pad state codes, ground first
    typedef enum logic [2:0] {
        PAD_GROUND,
        PAD_PULLDOWN,
        PAD_FLOATING,
        PAD_PULLUP,
        PAD_SUPPLY
    } pad_state_t;

    localparam int          ADDR_W        = 7;
    localparam int          PAD_COUNT     = 3;
    localparam int          LED_COUNT     = 16;
    localparam int          STATE_COUNT   = 5;
    localparam int          PAD_CODE_W    = 3;
    localparam logic [6:0]  ADDR_BASE     = 7'h01;
    localparam logic [6:0]  WEIGHT_ONE    = 7'h05;
    localparam logic [6:0]  WEIGHT_TWO    = 7'h19;
    localparam logic [6:0]  ADDR_RESET    = 7'h00;
    localparam logic [2:0]  CODE_RESET    = 3'h0;
    localparam logic [2:0]  CODE_MAX      = 3'h4;
    localparam logic [1:0]  SETTLE_RESET  = 2'h0;
    localparam logic [1:0]  SETTLE_LAST   = 2'h1;

    // one sampled code per pad
    typedef struct packed {
        logic [2:0] pad_two;
        logic [2:0] pad_one;
        logic [2:0] pad_zero;
    } pad_codes_t;

endpackage : addr_select_pkg

// [core/quinary_addr_select.sv]
// quinary pad address select, latch and output enable gating
`timescale 1ns/1ns
`default_nettype none

module quinary_addr_select (
    // clock and reset
    input  wire  logic                 CLOCK,
    input  wire  logic                 RESETN,
    input  wire  logic                 CLOCK_EN,
    // software reset request from the bus logic, same clock
    input  wire  logic                 SOFT_RESET,
    // classified pad states from the analog front end, asynchronous
    input  wire  logic [2:0]           ADDR_PAD_ZERO,
    input  wire  logic [2:0]           ADDR_PAD_ONE,
    input  wire  logic [2:0]           ADDR_PAD_TWO,
    // pad bias enable to the analog front end
    output var   logic                 PAD_SENSE_EN,
    // output enable pin, active low, asynchronous
    input  wire  logic                 OUTPUT_EN_N,
    // led request from the core, same clock
    input  wire  logic [15:0]          LED_REQ,
    // results
    output var   logic [6:0]           SLAVE_ADDR,
    output var   logic                 ADDR_VALID,
    output var   logic [15:0]          LED_OUT
);

    // ========================================
    // state
    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_CAPTURE,
        ST_HELD
    } phase_t;

    phase_t                        phase_q;
    phase_t                        phase_d;
    logic [1:0]                    settle_q;
    logic [1:0]                    settle_d;
    logic                          valid_d;
    logic                          sense_d;
    logic                          load_w;
    logic [15:0]                   led_d;
    addr_select_pkg::pad_codes_t   meta_q;
    addr_select_pkg::pad_codes_t   sync_q;
    addr_select_pkg::pad_codes_t   pads_w;
    logic [1:0]                    oe_sync_q;
    logic [6:0]                    addr_q;
    logic [6:0]                    addr_d;
    logic                          valid_q;
    logic                          sense_q;
    logic [15:0]                   led_q;

    // ========================================
    // pad synchronisers
    assign pads_w.pad_zero = ADDR_PAD_ZERO;
    assign pads_w.pad_one  = ADDR_PAD_ONE;
    assign pads_w.pad_two  = ADDR_PAD_TWO;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (CLOCK_EN) begin
            meta_q <= pads_w;
            sync_q <= meta_q;
        end
    end

    // ========================================
    // output enable synchroniser
    // resets to the disabled level so no led lights before sync fills
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            oe_sync_q <= 2'h3;
        end else if (CLOCK_EN) begin
            oe_sync_q <= {oe_sync_q[0], OUTPUT_EN_N};
        end
    end

    // ========================================
    // decode
    // out-of-range codes clamp to supply so every pad has one state
    logic [8:0] raw_w;
    logic [2:0] code_w [addr_select_pkg::PAD_COUNT];
    assign raw_w = sync_q;

    genvar g;
    generate
        for (g = 0; g < addr_select_pkg::PAD_COUNT; g++) begin : g_pad
            assign code_w[g] =
                (raw_w[g*addr_select_pkg::PAD_CODE_W +: 3]
                    > addr_select_pkg::CODE_MAX)
                ? addr_select_pkg::CODE_MAX
                : raw_w[g*addr_select_pkg::PAD_CODE_W +: 3];
        end
    endgenerate

    logic [6:0] term_two;
    logic [6:0] term_one;
    assign term_two = 7'(addr_select_pkg::WEIGHT_TWO * {4'h0, code_w[2]});
    assign term_one = 7'(addr_select_pkg::WEIGHT_ONE * {4'h0, code_w[1]});
    // ground-all gives 01, pad zero at supply gives 05
    assign addr_d = 7'(term_two + term_one + {4'h0, code_w[0]}
                    + addr_select_pkg::ADDR_BASE);

    // ========================================
    // sequence
    // settle waits until both synchroniser stages hold live pad codes
    always_comb begin
        phase_d  = phase_q;
        settle_d = settle_q;
        case (phase_q)
            ST_SETTLE: begin
                if (settle_q == addr_select_pkg::SETTLE_LAST) begin
                    phase_d = ST_CAPTURE;
                end else begin
                    settle_d = settle_q + 2'h1;
                end
            end
            ST_CAPTURE: phase_d = ST_HELD;
            ST_HELD:    phase_d = ST_HELD;
            default:    phase_d = ST_SETTLE;
        endcase
        if (SOFT_RESET) begin
            phase_d  = ST_SETTLE;
            settle_d = addr_select_pkg::SETTLE_RESET;
        end
    end

    // named next values
    assign load_w  = (phase_q == ST_CAPTURE) && !SOFT_RESET;
    assign valid_d = SOFT_RESET ? 1'b0 : (valid_q || load_w);
    assign sense_d = (phase_d != ST_HELD);
    assign led_d   = oe_sync_q[1] ? '0 : LED_REQ;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            phase_q  <= ST_SETTLE;
            settle_q <= addr_select_pkg::SETTLE_RESET;
        end else if (CLOCK_EN) begin
            phase_q  <= phase_d;
            settle_q <= settle_d;
        end
    end

    // ========================================
    // address latch
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            addr_q <= addr_select_pkg::ADDR_RESET;
        end else if (CLOCK_EN && load_w) begin
            addr_q <= addr_d;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            valid_q <= 1'b0;
        end else if (CLOCK_EN) begin
            valid_q <= valid_d;
        end
    end

    // ========================================
    // pad bias
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            sense_q <= 1'b1;
        end else if (CLOCK_EN) begin
            sense_q <= sense_d;
        end
    end

    // ========================================
    // led gating
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            led_q <= '0;
        end else if (CLOCK_EN) begin
            led_q <= led_d;
        end
    end

    assign SLAVE_ADDR   = addr_q;
    assign ADDR_VALID   = valid_q;
    assign PAD_SENSE_EN = sense_q;
    assign LED_OUT      = led_q;

endmodule : quinary_addr_select

`default_nettype wire

// [verif/pad_front_model.sv]
// pad front end model: strapped codes while biased, noise once released
`timescale 1ns/1ns
`default_nettype none
module pad_front_model (
    input wire logic CLOCK, PAD_SENSE_EN,
    input wire addr_select_pkg::pad_codes_t CODES,
    output var logic [2:0] ADDR_PAD_ZERO, ADDR_PAD_ONE, ADDR_PAD_TWO
);
    logic [8:0] junk_q = 9'h0;
    always @(posedge CLOCK) junk_q <= junk_q + 9'h49;
    assign {ADDR_PAD_TWO, ADDR_PAD_ONE, ADDR_PAD_ZERO} =
        PAD_SENSE_EN ? CODES : junk_q;
endmodule : pad_front_model
`default_nettype wire

// [verif/addr_select_asserts.sv]
// checker: port assertions of the address select block
`timescale 1ns/1ns
`default_nettype none
module addr_select_chk (
    input wire logic CLOCK, RESETN, CLOCK_EN, SOFT_RESET, OUTPUT_EN_N,
    input wire logic PAD_SENSE_EN, ADDR_VALID,
    input wire logic [15:0] LED_REQ, LED_OUT,
    input wire logic [6:0] SLAVE_ADDR
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    property p_rng; ADDR_VALID |-> SLAVE_ADDR inside {[1:125]}; endproperty
    a_rng: assert property (p_rng) else $error("addr range");
    property p_off; ADDR_VALID |-> !PAD_SENSE_EN; endproperty
    a_off: assert property (p_off) else $error("pads on");
    property p_sw; CLOCK_EN && SOFT_RESET |=> !ADDR_VALID && PAD_SENSE_EN;
    endproperty
    a_sw: assert property (p_sw) else $error("soft reset");
    property p_cap; (PAD_SENSE_EN && CLOCK_EN && !SOFT_RESET)[*3]
        |=> ADDR_VALID; endproperty
    a_cap: assert property (p_cap) else $error("no capture");
    property p_hold; ADDR_VALID && !SOFT_RESET |=> $stable(SLAVE_ADDR);
    endproperty
    a_hold: assert property (p_hold) else $error("addr moved");
    property p_oe; (CLOCK_EN && OUTPUT_EN_N)[*4] |=> LED_OUT == 16'h0;
    endproperty
    a_oe: assert property (p_oe) else $error("led on");
    property p_led; (CLOCK_EN && !OUTPUT_EN_N)[*4]
        |=> LED_OUT == $past(LED_REQ); endproperty
    a_led: assert property (p_led) else $error("led data");
    property p_frz; !CLOCK_EN |=> $stable({SLAVE_ADDR, LED_OUT}); endproperty
    a_frz: assert property (p_frz) else $error("not frozen");
    cover property (SOFT_RESET && CLOCK_EN);
    cover property ($rose(ADDR_VALID));
    cover property (!CLOCK_EN);
endmodule : addr_select_chk
bind quinary_addr_select addr_select_chk u_chk (.*);
`default_nettype wire

// [verif/tb.sv]
// testbench: address capture, soft reset, output enable, freeze
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic CLOCK = 0, RESETN = 0, CLOCK_EN = 1, SOFT_RESET = 0;
    logic OUTPUT_EN_N = 1, ADDR_VALID, PAD_SENSE_EN;
    logic [15:0] LED_REQ = 16'h0, LED_OUT;
    logic [6:0] SLAVE_ADDR;
    logic [2:0] ADDR_PAD_ZERO, ADDR_PAD_ONE, ADDR_PAD_TWO;
    addr_select_pkg::pad_codes_t CODES = 9'h0;
    int errors = 0, n_checks = 0;
    logic [31:0] rng = 32'h4045bb9d;
    pad_front_model pm (.*);
    quinary_addr_select dut (.*);
    initial forever #2 CLOCK = ~CLOCK;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic int cl(input logic [2:0] v);
        return (v > 3'h4) ? 4 : int'(v);
    endfunction : cl
    function automatic logic [6:0] want(input addr_select_pkg::pad_codes_t c);
        return 7'(25 * cl(c.pad_two) + 5 * cl(c.pad_one) + cl(c.pad_zero) + 1);
    endfunction : want
    task automatic chk(input string s, input logic [15:0] e, g);
        n_checks++;
        if (e !== g)
            $display("[ERR] %s expected %h seen %h", s, e, g);
        errors += int'(e !== g);
    endtask : chk
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    task automatic capture(input addr_select_pkg::pad_codes_t c, input bit sw);
        @(negedge CLOCK);
        CODES = c;
        SOFT_RESET = sw;
        RESETN = sw;
        repeat (3) @(negedge CLOCK);
        {SOFT_RESET, RESETN} = 2'b01;
        repeat (3) @(negedge CLOCK);
        chk("addr", 16'(want(c)), 16'(SLAVE_ADDR));
        chk("valid", 16'h2, 16'({ADDR_VALID, PAD_SENSE_EN}));
        $display("capture %h done", c);
    endtask : capture
    initial begin
        repeat (6) @(negedge CLOCK);
        capture(9'h0, 0);
        capture(9'h4, 1);
        capture(9'h124, 0);
        capture(9'h1ff, 1);
        repeat (8) begin
            rng = xs(rng);
            capture({3'(rng[7:0] % 5), 3'(rng[15:8] % 5),
                3'(rng[23:16] % 5)}, rng[31]);
        end
        {OUTPUT_EN_N, LED_REQ} = {1'b0, rng[15:0]};
        repeat (4) @(negedge CLOCK);
        chk("led", LED_REQ, LED_OUT);
        {CLOCK_EN, LED_REQ} = {1'b0, ~rng[15:0]};
        repeat (3) @(negedge CLOCK);
        chk("frozen", rng[15:0], LED_OUT);
        {CLOCK_EN, OUTPUT_EN_N} = 2'b11;
        repeat (4) @(negedge CLOCK);
        chk("led off", 16'h0, LED_OUT);
        $display("led test done");
        results();
    end
    initial begin
        #20000;
        errors++;
        results();
    end
endmodule : tb
`default_nettype wire
